// >>> reference_switch_control.sv
`timescale 1ns/100ps
// Behaviour
// RL1 - Left switch acts only when enabled (the position latch still uses left switch edges when enLeft is clear)
// RL2 - Right switch acts only when enabled
// RL3 - Left switch polarity selectable
// RL4 - Right switch polarity selectable
// RL5 - Switch to direction mapping, swappable
// RL6 - Hard external stop zeroes velocity
// RL7 - Soft external stop ramps velocity down
// RL8 - Left virtual limit only when enabled
// RL9 - Right virtual limit only when enabled
// RL10 - Virtual mode one is hard stop
// RL11 - Virtual mode two is soft ramp
// RL12 - Latch position when left goes inactive
// RL13 - Latch position when left goes active
// RL14 - Switch configuration resets to zero
// RL15 - Latched position readable at readback
// RL16 - Synchronise inputs, detect edges after polarity
// RL17 - Block only toward stopped direction
module reference_switch_control
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [ref_stop_pkg::ADDR_W-1:0] address,
   input wire logic [ref_stop_pkg::DATA_W-1:0] writeData,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   output logic [ref_stop_pkg::DATA_W-1:0] readData,
   input wire logic leftSwitchInput,
   input wire logic rightSwitchInput,
   input wire logic signed [ref_stop_pkg::DATA_W-1:0] actualPosition,
   input wire logic signed [ref_stop_pkg::DATA_W-1:0] velocityIn,
   input wire logic [ref_stop_pkg::DATA_W-1:0] revolutionCountReadback,
   output logic signed [ref_stop_pkg::DATA_W-1:0] actualVelocity,
   output logic blockNegative,
   output logic blockPositive,
   output logic irq
);

   localparam int DW = ref_stop_pkg::DATA_W;

   ref_stop_pkg::ref_config_t refConfig;
   ref_stop_pkg::ref_config_t writeConfig;
   ref_stop_pkg::switch_state_t leftState;
   ref_stop_pkg::switch_state_t rightState;

   logic latchSelect;
   logic [ref_stop_pkg::IRQ_W-1:0] irqStatus;
   logic [ref_stop_pkg::IRQ_W-1:0] irqMask;
   logic [ref_stop_pkg::IRQ_W-1:0] irqSet;
   logic [ref_stop_pkg::IRQ_W-1:0] irqClear;
   logic signed [DW-1:0] virtLeftLimit;
   logic signed [DW-1:0] virtRightLimit;
   logic [DW-1:0] softDecelStep;
   logic signed [DW-1:0] latchedPosition;

   logic leftOn;
   logic rightOn;
   logic extBlockNeg;
   logic extBlockPos;
   logic virtBlockNeg;
   logic virtBlockPos;
   logic movingNeg;
   logic movingPos;
   logic extStop;
   logic virtStop;
   logic virtHardMode;
   logic holdHard;
   logic holdSoft;
   logic extStopPrev;
   logic virtStopPrev;
   logic latchEvent;

   logic writeGeneral;
   logic writeRefConfig;
   logic writeStatus;
   logic writeMask;
   logic writeLeftLimit;
   logic writeRightLimit;
   logic writeDecel;

   // Register write decode
   assign writeGeneral = writeStrobe &
      (address == ref_stop_pkg::ADDR_GENERAL_CONFIG);
   assign writeRefConfig = writeStrobe &
      (address == ref_stop_pkg::ADDR_REFERENCE_SWITCH_CONFIG);
   assign writeStatus = writeStrobe &
      (address == ref_stop_pkg::ADDR_IRQ_STATUS);
   assign writeMask = writeStrobe &
      (address == ref_stop_pkg::ADDR_IRQ_MASK);
   assign writeLeftLimit = writeStrobe &
      (address == ref_stop_pkg::ADDR_VIRTUAL_LEFT_LIMIT);
   assign writeRightLimit = writeStrobe &
      (address == ref_stop_pkg::ADDR_VIRTUAL_RIGHT_LIMIT);
   assign writeDecel = writeStrobe &
      (address == ref_stop_pkg::ADDR_SOFT_DECEL_STEP);

   // Reserved bits never stored, so they read back as zero
   always_comb
   begin
      writeConfig = ref_stop_pkg::ref_config_t'(writeData);
      writeConfig.reserved = '0;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         refConfig <= ref_stop_pkg::ref_config_t'(
            ref_stop_pkg::REF_CONFIG_RESET); // RL14
      else if (writeRefConfig)
         refConfig <= writeConfig;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         latchSelect <= 1'b0;
      else if (writeGeneral)
         latchSelect <= writeData[ref_stop_pkg::GEN_LATCH_SELECT_BIT];
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         virtLeftLimit <= ref_stop_pkg::LIMIT_RESET;
         virtRightLimit <= ref_stop_pkg::LIMIT_RESET;
      end
      else
      begin
         if (writeLeftLimit)
            virtLeftLimit <= writeData;
         if (writeRightLimit)
            virtRightLimit <= writeData;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         softDecelStep <= ref_stop_pkg::DECEL_RESET;
      else if (writeDecel)
         softDecelStep <= writeData;
   end

   // Switch inputs
   stop_switch_sync u_left_sync
   (
      .clock(clock),
      .rst(rst),
      .pinIn(leftSwitchInput),
      .activeHigh(refConfig.polLeft), // RL3
      .state(leftState)
   );

   stop_switch_sync u_right_sync
   (
      .clock(clock),
      .rst(rst),
      .pinIn(rightSwitchInput),
      .activeHigh(refConfig.polRight), // RL4
      .state(rightState)
   );

   assign leftOn = leftState.active & refConfig.enLeft; // RL1
   assign rightOn = rightState.active & refConfig.enRight; // RL2

   // Default left guards negative travel, right guards positive
   assign extBlockNeg = refConfig.invertStopDirection ? rightOn : leftOn; // RL5
   assign extBlockPos = refConfig.invertStopDirection ? leftOn : rightOn; // RL5

   assign virtBlockNeg = refConfig.virtLeftEn &
      (actualPosition <= virtLeftLimit); // RL8
   assign virtBlockPos = refConfig.virtRightEn &
      (actualPosition >= virtRightLimit); // RL9

   // Direction taken from the commanded velocity
   assign movingNeg = velocityIn[DW-1];
   assign movingPos = ~velocityIn[DW-1] & (|velocityIn);

   assign extStop = (extBlockNeg & movingNeg) |
      (extBlockPos & movingPos); // RL17
   assign virtStop = (virtBlockNeg & movingNeg) |
      (virtBlockPos & movingPos); // RL17

   // Reserved mode codes fall back to the safer hard stop
   assign virtHardMode = refConfig.virtStopMode != ref_stop_pkg::VIRT_SOFT; // RL10

   // Hard stop wins when both kinds of stop are pending
   assign holdHard = (extStop & ~refConfig.softStopEn) |
      (virtStop & virtHardMode); // RL6 RL10
   assign holdSoft = (extStop & refConfig.softStopEn) |
      (virtStop & ~virtHardMode); // RL7 RL11

   stop_velocity_ramp
   #(
      .W(DW)
   )
   u_ramp
   (
      .clock(clock),
      .rst(rst),
      .velocityIn(velocityIn),
      .holdHard(holdHard),
      .holdSoft(holdSoft),
      .decelStep(softDecelStep),
      .velocityOut(actualVelocity)
   );

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         blockNegative <= 1'b0;
         blockPositive <= 1'b0;
      end
      else
      begin
         blockNegative <= extBlockNeg | virtBlockNeg; // RL17
         blockPositive <= extBlockPos | virtBlockPos; // RL17
      end
   end

   // Position latch on left switch edges, independent of its enable
   assign latchEvent =
      (refConfig.latchOnInactiveLeft & leftState.becameInactive) | // RL12
      (refConfig.latchOnActiveLeft & leftState.becameActive); // RL13

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         latchedPosition <= '0;
      else if (latchEvent)
         latchedPosition <= actualPosition; // RL12 RL13
   end

   // Interrupt events
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         extStopPrev <= 1'b0;
         virtStopPrev <= 1'b0;
      end
      else
      begin
         extStopPrev <= extStop;
         virtStopPrev <= virtStop;
      end
   end

   always_comb
   begin
      irqSet = '0;
      irqSet[ref_stop_pkg::IRQ_EXT_STOP] = extStop & ~extStopPrev;
      irqSet[ref_stop_pkg::IRQ_VIRT_STOP] = virtStop & ~virtStopPrev;
      irqSet[ref_stop_pkg::IRQ_LATCH] = latchEvent;
      irqClear = writeStatus ? writeData[ref_stop_pkg::IRQ_W-1:0] : '0;
   end

   // A new event in the clearing cycle stays set
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         irqStatus <= '0;
      else
         irqStatus <= (irqStatus & ~irqClear) | irqSet;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         irqMask <= '0;
      else if (writeMask)
         irqMask <= writeData[ref_stop_pkg::IRQ_W-1:0];
   end

   assign irq = |(irqStatus & irqMask);

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         readData <= '0;
      else if (readStrobe)
      begin
         case (address)
            ref_stop_pkg::ADDR_GENERAL_CONFIG:
            begin
               readData <= '0;
               readData[ref_stop_pkg::GEN_LATCH_SELECT_BIT] <= latchSelect;
            end
            ref_stop_pkg::ADDR_REFERENCE_SWITCH_CONFIG:
               readData <= refConfig;
            ref_stop_pkg::ADDR_LATCH_READBACK:
               readData <= latchSelect ? revolutionCountReadback
                  : latchedPosition; // RL15
            ref_stop_pkg::ADDR_IRQ_STATUS:
               readData <= DW'(irqStatus);
            ref_stop_pkg::ADDR_IRQ_MASK:
               readData <= DW'(irqMask);
            ref_stop_pkg::ADDR_VIRTUAL_LEFT_LIMIT:
               readData <= virtLeftLimit;
            ref_stop_pkg::ADDR_VIRTUAL_RIGHT_LIMIT:
               readData <= virtRightLimit;
            ref_stop_pkg::ADDR_SOFT_DECEL_STEP:
               readData <= softDecelStep;
            default:
               readData <= '0;
         endcase
      end
      else
         readData <= '0;
   end

endmodule : reference_switch_control

// >>> ref_stop_pkg.sv
package ref_stop_pkg;

   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;

   // Register map, byte-free word offsets on the plain register port
   localparam logic [ADDR_W-1:0] ADDR_GENERAL_CONFIG = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_REFERENCE_SWITCH_CONFIG = 8'h01;
   localparam logic [ADDR_W-1:0] ADDR_LATCH_READBACK = 8'h36;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h40;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h41;
   localparam logic [ADDR_W-1:0] ADDR_VIRTUAL_LEFT_LIMIT = 8'h42;
   localparam logic [ADDR_W-1:0] ADDR_VIRTUAL_RIGHT_LIMIT = 8'h43;
   localparam logic [ADDR_W-1:0] ADDR_SOFT_DECEL_STEP = 8'h44;

   // General configuration: only the readback select bit is kept here
   localparam int GEN_LATCH_SELECT_BIT = 27;

   localparam logic [DATA_W-1:0] REF_CONFIG_RESET = 32'h00000000;
   localparam logic [DATA_W-1:0] LIMIT_RESET = 32'h00000000;
   localparam logic [DATA_W-1:0] DECEL_RESET = 32'h00000001;

   // Interrupt status and mask layout
   localparam int IRQ_W = 3;
   localparam int IRQ_EXT_STOP = 0;
   localparam int IRQ_VIRT_STOP = 1;
   localparam int IRQ_LATCH = 2;

   typedef enum logic [1:0]
   {
      VIRT_RESERVED_LOW = 2'h0,
      VIRT_HARD = 2'h1,
      VIRT_SOFT = 2'h2,
      VIRT_RESERVED_HIGH = 2'h3
   } virt_mode_t;

   typedef struct packed
   {
      logic [19:0] reserved;
      logic latchOnActiveLeft;
      logic latchOnInactiveLeft;
      virt_mode_t virtStopMode;
      logic virtRightEn;
      logic virtLeftEn;
      logic softStopEn;
      logic invertStopDirection;
      logic polRight;
      logic polLeft;
      logic enRight;
      logic enLeft;
   } ref_config_t;

   typedef struct packed
   {
      logic active;
      logic becameActive;
      logic becameInactive;
   } switch_state_t;

endpackage : ref_stop_pkg

// >>> stop_switch_sync.sv
`timescale 1ns/100ps
module stop_switch_sync
(
   input wire logic clock,
   input wire logic rst,
   input wire logic pinIn,
   input wire logic activeHigh,
   output ref_stop_pkg::switch_state_t state
);

   logic syncFirst;
   logic syncSecond;
   logic level;
   logic prevLevel;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         // Idle pin level under reset polarity: no false edge after reset
         syncFirst <= 1'b1;
         syncSecond <= 1'b1;
      end
      else
      begin
         syncFirst <= pinIn;
         syncSecond <= syncFirst;
      end
   end

   // Polarity change may itself show as one edge
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         level <= 1'b0;
         prevLevel <= 1'b0;
      end
      else
      begin
         level <= activeHigh ? syncSecond : ~syncSecond; // RL16
         prevLevel <= level; // RL16
      end
   end

   assign state.active = level;
   assign state.becameActive = level & ~prevLevel; // RL16
   assign state.becameInactive = ~level & prevLevel; // RL16

endmodule : stop_switch_sync

// >>> stop_velocity_ramp.sv
`timescale 1ns/100ps
module stop_velocity_ramp
#(
   parameter int W = 32
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic signed [W-1:0] velocityIn,
   input wire logic holdHard,
   input wire logic holdSoft,
   input wire logic [W-1:0] decelStep,
   output logic signed [W-1:0] velocityOut
);

   logic [W-1:0] magnitude;
   logic signed [W-1:0] next_velocity;

   always_comb
   begin
      magnitude = velocityOut[W-1] ? W'(-velocityOut) : W'(velocityOut);
      if (holdHard)
         next_velocity = '0;
      else if (holdSoft)
      begin
         // Never overshoots through zero into the blocked direction
         if (magnitude <= decelStep)
            next_velocity = '0;
         else if (velocityOut[W-1])
            next_velocity = W'(velocityOut + $signed(decelStep));
         else
            next_velocity = W'(velocityOut - $signed(decelStep));
      end
      else
         next_velocity = velocityIn;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         velocityOut <= '0;
      else
         velocityOut <= next_velocity;
   end

endmodule : stop_velocity_ramp

// >>> ref_switch_chk.sv
`timescale 1ns/100ps
module ref_switch_chk
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] address,
   input wire logic [31:0] writeData,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   input wire logic [31:0] readData,
   input wire logic signed [31:0] velocityIn,
   input wire logic signed [31:0] actualVelocity,
   input wire logic blockNegative,
   input wire logic blockPositive,
   input wire logic irq
);
   logic [31:0] cfg;
   logic [31:0] cfgD1;
   logic [31:0] cfgD2;
   logic [2:0] mask;
   logic cfgSteady;
   // Shadow copies from observed writes, since internals are not visible
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         cfg <= 32'h0;
      else if (writeStrobe && address == 8'h01)
         cfg <= writeData;
   end
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         mask <= 3'h0;
      else if (writeStrobe && address == 8'h41)
         mask <= writeData[2:0];
   end
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cfgD1 <= 32'h0;
         cfgD2 <= 32'h0;
      end
      else
      begin
         cfgD1 <= cfg;
         cfgD2 <= cfgD1;
      end
   end
   // Block outputs lag a config change by up to two cycles
   assign cfgSteady = cfg == cfgD1 && cfg == cfgD2;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   chk_cfg_readback:
      assert property (readStrobe && address == 8'h01 |=>
         readData == {20'h0, $past(cfg[11:0])}) else $error("cfg readback");
   chk_idle_noblock:
      assert property (cfgSteady && cfg[1:0] == 2'h0 && cfg[7:6] == 2'h0
         |-> !blockNegative && !blockPositive) else $error("block disabled");
   chk_left_dir:
      assert property (cfgSteady && !cfg[1] && cfg[7:6] == 2'h0 |->
         (cfg[4] ? !blockNegative : !blockPositive)) else $error("direction");
   chk_pass_through:
      assert property (!blockNegative && !blockPositive &&
         $past(!blockNegative && !blockPositive) |->
         actualVelocity == $past(velocityIn)) else $error("pass through");
   chk_hard_zero:
      assert property ((blockNegative && $past(blockNegative) &&
         $past(velocityIn[31]) || blockPositive && $past(blockPositive) &&
         !$past(velocityIn[31]) && $past(velocityIn) != 32'h0) &&
         !$past(cfg[5]) && $past(cfg[9:8]) != 2'h2 |->
         actualVelocity == 32'h0)
         else $error("hard stop");
   chk_soft_sign:
      assert property (blockNegative && $past(blockNegative) &&
         $past(velocityIn[31]) && $past(actualVelocity[31] ||
         actualVelocity == 32'h0) |-> actualVelocity[31] ||
         actualVelocity == 32'h0) else $error("ramp crossed zero");
   chk_reverse_free:
      assert property (blockNegative && !blockPositive &&
         $past(blockNegative && !blockPositive) && !$past(velocityIn[31])
         |-> actualVelocity == $past(velocityIn)) else $error("reverse");
   chk_irq_masked:
      assert property (mask == 3'h0 |-> !irq) else $error("irq masked");
   cover property (blockNegative && actualVelocity == 32'h0);
   cover property (blockPositive && actualVelocity == 32'h0);
   cover property (irq);
endmodule : ref_switch_chk

bind reference_switch_control ref_switch_chk u_ref_switch_chk
(
   .clock(clock), .rst(rst), .address(address), .writeData(writeData),
   .writeStrobe(writeStrobe), .readStrobe(readStrobe),
   .readData(readData), .velocityIn(velocityIn),
   .actualVelocity(actualVelocity), .blockNegative(blockNegative),
   .blockPositive(blockPositive), .irq(irq)
);

// >>> stop_switch_model.sv
`timescale 1ns/100ps
module stop_switch_model
(
   input wire logic pressLeft,
   input wire logic pressRight,
   input wire logic polLeft,
   input wire logic polRight,
   output logic leftPin,
   output logic rightPin
);
   // Contacts change off the clock grid, as real switches do
   assign #2 leftPin = polLeft ? pressLeft : !pressLeft;
   assign #2 rightPin = polRight ? pressRight : !pressRight;
endmodule : stop_switch_model

// >>> testbench.sv
`timescale 1ns/100ps
module testbench;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] address = 8'h0;
   logic [31:0] writeData = 32'h0;
   logic writeStrobe = 1'b0;
   logic readStrobe = 1'b0;
   logic signed [31:0] actualPosition = 32'h0;
   logic signed [31:0] velocityIn = 32'h0;
   logic pressLeft = 1'b0;
   logic pressRight = 1'b0;
   logic polRight = 1'b0;
   logic [31:0] readData;
   logic signed [31:0] actualVelocity;
   logic leftPin;
   logic rightPin;
   logic blockNegative;
   logic blockPositive;
   logic irq;
   int n_fail = 0;
   int n_checks = 0;
   always #2.5 clock = !clock;
   stop_switch_model u_stop_switch_model (.pressLeft(pressLeft),
      .pressRight(pressRight), .polLeft(1'b0), .polRight(polRight),
      .leftPin(leftPin), .rightPin(rightPin));
   reference_switch_control u_reference_switch_control (.clock(clock),
      .rst(rst), .address(address), .writeData(writeData),
      .writeStrobe(writeStrobe), .readStrobe(readStrobe),
      .readData(readData), .leftSwitchInput(leftPin),
      .rightSwitchInput(rightPin), .actualPosition(actualPosition),
      .velocityIn(velocityIn), .revolutionCountReadback(32'h0000C0DE),
      .actualVelocity(actualVelocity), .blockNegative(blockNegative),
      .blockPositive(blockPositive), .irq(irq));
   task automatic report_and_stop;
      $display("checks=%0d fails=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      address <= a;
      writeData <= d;
      writeStrobe <= 1'b1;
      @(posedge clock);
      writeStrobe <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      address <= a;
      readStrobe <= 1'b1;
      @(posedge clock);
      readStrobe <= 1'b0;
      #1;
      check(readData, exp);
   endtask : rd
   task automatic t_reset;
      rd(8'h01, 32'h0);
      rd(8'h10, 32'h0);
      rd(8'h41, 32'h0);
   endtask : t_reset
   task automatic t_hard_left;
      @(posedge clock);
      velocityIn <= 32'hFFFFFF9C;
      pressLeft <= 1'b1;
      cyc(6);
      check(actualVelocity, 32'hFFFFFF9C);
      wr(8'h41, 32'h00000001);
      wr(8'h01, 32'h00000101);
      cyc(6);
      check(actualVelocity, 32'h0);
      check({31'h0, blockNegative}, 32'h1);
      check({31'h0, irq}, 32'h1);
      rd(8'h40, 32'h00000001);
      @(posedge clock);
      velocityIn <= 32'h00000032;
      cyc(3);
      check(actualVelocity, 32'h00000032);
      wr(8'h01, 32'h00000111);
      cyc(4);
      check(actualVelocity, 32'h0);
      wr(8'h40, 32'h00000007);
      cyc(1);
      check({31'h0, irq}, 32'h0);
      @(posedge clock);
      velocityIn <= 32'hFFFFFFCE;
      wr(8'h01, 32'h00000105);
      cyc(6);
      check(actualVelocity, 32'hFFFFFFCE);
   endtask : t_hard_left
   task automatic t_right;
      @(posedge clock);
      pressLeft <= 1'b0;
      polRight <= 1'b1;
      pressRight <= 1'b1;
      velocityIn <= 32'h00000046;
      wr(8'h01, 32'h0000010A);
      cyc(6);
      check(actualVelocity, 32'h0);
      check({31'h0, blockPositive}, 32'h1);
      @(posedge clock);
      velocityIn <= 32'hFFFFFFBA;
      cyc(3);
      check(actualVelocity, 32'hFFFFFFBA);
      wr(8'h01, 32'h00000108);
      @(posedge clock);
      velocityIn <= 32'h00000046;
      cyc(6);
      check(actualVelocity, 32'h00000046);
      pressRight <= 1'b0;
   endtask : t_right
   task automatic t_soft;
      int i;
      wr(8'h44, 32'h00000010);
      wr(8'h01, 32'h00000121);
      @(posedge clock);
      velocityIn <= 32'hFFFFFFC0;
      cyc(4);
      @(posedge clock);
      pressLeft <= 1'b1;
      cyc(1);
      for (i = 0; i < 10 && actualVelocity === 32'hFFFFFFC0; i++)
         cyc(1);
      if (i == 10)
      begin
         n_fail++;
         report_and_stop;
      end
      check(actualVelocity, 32'hFFFFFFD0);
      cyc(3);
      check(actualVelocity, 32'h0);
      pressLeft <= 1'b0;
   endtask : t_soft
   task automatic t_virtual;
      wr(8'h42, 32'h00000064);
      wr(8'h43, 32'h00000028);
      @(posedge clock);
      actualPosition <= 32'h00000032;
      velocityIn <= 32'hFFFFFFEC;
      wr(8'h01, 32'h00000100);
      cyc(4);
      check(actualVelocity, 32'hFFFFFFEC);
      wr(8'h01, 32'h00000140);
      cyc(4);
      check(actualVelocity, 32'h0);
      @(posedge clock);
      velocityIn <= 32'h00000040;
      cyc(4);
      check(actualVelocity, 32'h00000040);
      wr(8'h01, 32'h00000280);
      cyc(2);
      check({31'h0, actualVelocity == 32'h0}, 32'h0);
      cyc(6);
      check(actualVelocity, 32'h0);
   endtask : t_virtual
   task automatic t_latch;
      wr(8'h01, 32'h00000900);
      @(posedge clock);
      actualPosition <= 32'h00001234;
      pressLeft <= 1'b1;
      cyc(6);
      @(posedge clock);
      actualPosition <= 32'h00005678;
      wr(8'h01, 32'h00000500);
      rd(8'h36, 32'h00001234);
      @(posedge clock);
      actualPosition <= 32'h00009ABC;
      pressLeft <= 1'b0;
      cyc(6);
      @(posedge clock);
      actualPosition <= 32'h0;
      wr(8'h01, 32'h00000100);
      rd(8'h36, 32'h00009ABC);
      @(posedge clock);
      pressLeft <= 1'b1;
      cyc(6);
      rd(8'h36, 32'h00009ABC);
      wr(8'h00, 32'h08000000);
      rd(8'h36, 32'h0000C0DE);
      rd(8'h40, 32'h00000007);
   endtask : t_latch
   initial
   begin
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      t_reset;
      t_hard_left;
      t_right;
      t_soft;
      t_virtual;
      t_latch;
      report_and_stop;
   end
endmodule : testbench
